// file: hdl/mmt_timer.sv
// The implementer's own choices: the AXI4-Lite interface to the registers and the register offsets.
`include "mmt_map.svh"
`default_nettype none
// Function
// - Timer mode counts ticks, match clears, interrupts.
// - Soft capture copies counter into capture.
// - Low byte write suspends compare until high.
// - Ignore matches one machine cycle after high.
// - Capture register writable only in generator mode.
// - Reset leaves both timer registers untouched.
// - Trigger mode starts counting on chosen edge.
// - Trigger match interrupts, clears, halts; early edges ignored.
// - Optional reverse edge clears and stops counter.
// - Input filter rejects short pulses, needs long ones.
// - Event mode counts pin edges, match clears.
// - Window mode counts ticks gated by pin level.
// - Width mode captures on opposite edge, interrupts.
// - Double-edge mode captures again, keeps running.
// - Generator capture match toggles, maskable interrupt.
// - Generator period match toggles, clears, interrupts.
// - Flip-flop resets low, presettable, drives pin.
module mmt_timer
  import mmt_pkg::*;
#(
  parameter int DIV_SLOW = 8192,
  parameter int DIV_MID  = 256,
  parameter int DIV_FAST = 16
) (
  // Clock and reset.
  input  wire logic                 i_clk,
  input  wire logic                 i_reset,
  // AXI4-Lite write channels.
  input  wire logic [7:0]           i_awaddr,
  input  wire logic                 i_awvalid,
  output logic                      o_awready,
  input  wire logic [31:0]          i_wdata,
  input  wire logic [3:0]           i_wstrb,
  input  wire logic                 i_wvalid,
  output logic                      o_wready,
  output logic [1:0]                o_bresp,
  output logic                      o_bvalid,
  input  wire logic                 i_bready,
  // AXI4-Lite read channels.
  input  wire logic [7:0]           i_araddr,
  input  wire logic                 i_arvalid,
  output logic                      o_arready,
  output logic [31:0]               o_rdata,
  output logic [1:0]                o_rresp,
  output logic                      o_rvalid,
  input  wire logic                 i_rready,
  // Pins and system state.
  input  wire logic                 i_timer1_input_pin,
  input  wire logic                 i_slow_mode,
  output logic                      o_pulse_output_pin,
  output logic                      o_timer1_interrupt
);
  import mmt_pkg::*;

  localparam int FILT_W = 6;
  localparam logic [FILT_W-1:0] DETECT_CYC  = FILT_W'(`MMT_DETECT_CYC);
  localparam logic [FILT_W-1:0] MACHINE_CYC = FILT_W'(`MMT_MACHINE_CYC);
  localparam logic [2:0]        HOLD_CYC    = 3'(`MMT_MACHINE_CYC);
  localparam int FILT_LAST = `MMT_DETECT_CYC - 1;

  logic [7:0]        awaddr;
  logic [31:0]       wdata;
  logic [3:0]        wstrb;
  logic              wr_fire;
  logic              wr_lane;
  logic [7:0]        ctrl;
  logic [7:0]        aux;
  logic [15:0]       period;
  logic [15:0]       capture;
  logic              period_armed;
  logic              capture_armed;
  logic [2:0]        hold_a;
  logic [2:0]        hold_b;
  logic [15:0]       cnt;
  logic              running;
  mmt_pw_phase_t     phase;
  logic              ff;
  logic [1:0]        pin_sync;
  logic [1:0]        slow_sync;
  logic              pin_lvl;
  logic              pin_prev;
  logic [FILT_W-1:0] filt_cnt;
  logic [15:0]       pre;
  logic              tick;
  mmt_mode_t         mode;
  mmt_start_t        start;
  logic              rise;
  logic              fall;
  logic              trig_edge;
  logic              opp_edge;
  logic              w_trig;
  logic              w_opp;
  logic [15:0]       inc;
  logic              match_a;
  logic              match_b;
  logic [15:0]       next_cnt;
  logic              next_running;
  mmt_pw_phase_t     next_phase;
  logic              tog;
  logic              irq_evt;
  logic              cap_evt;
  logic              ctl_wr;
  logic              soft_cap;
  logic              per_lo_wr;
  logic              per_hi_wr;
  logic              cap_lo_wr;
  logic              cap_hi_wr;

  assign mode      = ctrl[`MMT_CTL_MODE_MSB:`MMT_CTL_MODE_LSB];
  assign start     = ctrl[`MMT_CTL_START_MSB:`MMT_CTL_START_LSB];
  assign rise      = pin_lvl & ~pin_prev;
  assign fall      = ~pin_lvl & pin_prev;
  assign trig_edge = aux[`MMT_AUX_TRIG_EDGE] ? fall : rise;
  assign opp_edge  = aux[`MMT_AUX_TRIG_EDGE] ? rise : fall;
  assign w_trig    = aux[`MMT_AUX_WIDTH_EDGE] ? fall : rise;
  assign w_opp     = aux[`MMT_AUX_WIDTH_EDGE] ? rise : fall;
  assign inc       = 16'(cnt + 16'h0001);

  // Bus write decode; only byte lane 0 carries register data.
  assign wr_fire   = ~o_awready & ~o_wready & ~o_bvalid;
  assign wr_lane   = wr_fire & wstrb[0];
  assign ctl_wr    = wr_lane & (awaddr == `MMT_OFS_CONTROL);
  assign per_lo_wr = wr_lane & (awaddr == `MMT_OFS_PERIOD_LO);
  assign per_hi_wr = wr_lane & (awaddr == `MMT_OFS_PERIOD_HI);
  assign cap_lo_wr = wr_lane & (awaddr == `MMT_OFS_CAPTURE_LO) & (mode == `MMT_MODE_PPG);
  assign cap_hi_wr = wr_lane & (awaddr == `MMT_OFS_CAPTURE_HI) & (mode == `MMT_MODE_PPG);
  assign soft_cap  = ctl_wr & wdata[`MMT_CTL_SHARED]
                   & ((wdata[2:0] == `MMT_MODE_TIMER) | (wdata[2:0] == `MMT_MODE_EVENT));

  // Address and data are held until both have arrived, in either order.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_awready <= 1'b1;
      o_wready  <= 1'b1;
      o_bvalid  <= 1'b0;
      o_bresp   <= 2'h0;
      awaddr    <= 8'h00;
      wdata     <= 32'h0000_0000;
      wstrb     <= 4'h0;
    end else begin
      if (i_awvalid && o_awready) begin
        o_awready <= 1'b0;
        awaddr    <= i_awaddr;
      end else if (o_bvalid && i_bready) begin
        o_awready <= 1'b1;
      end
      if (i_wvalid && o_wready) begin
        o_wready <= 1'b0;
        wdata    <= i_wdata;
        wstrb    <= i_wstrb;
      end else if (o_bvalid && i_bready) begin
        o_wready <= 1'b1;
      end
      if (wr_fire) begin
        o_bvalid <= 1'b1;
        o_bresp  <= (awaddr <= `MMT_OFS_AUX && awaddr[1:0] == 2'h0) ? 2'h0 : 2'h2;
      end else if (i_bready) begin
        o_bvalid <= 1'b0;
      end
    end
  end

  // Control and period stay write-only; they read as zero.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_arready <= 1'b1;
      o_rvalid  <= 1'b0;
      o_rdata   <= 32'h0000_0000;
      o_rresp   <= 2'h0;
    end else if (i_arvalid && o_arready) begin
      o_arready <= 1'b0;
      o_rvalid  <= 1'b1;
      o_rresp   <= 2'h0;
      case (i_araddr)
        `MMT_OFS_CONTROL, `MMT_OFS_PERIOD_LO, `MMT_OFS_PERIOD_HI: o_rdata <= 32'h0000_0000;
        `MMT_OFS_CAPTURE_LO: o_rdata <= {16'h0000, capture};
        `MMT_OFS_CAPTURE_HI: o_rdata <= {24'h00_0000, capture[15:8]};
        `MMT_OFS_AUX:        o_rdata <= {24'h00_0000, aux};
        `MMT_OFS_STATUS:     o_rdata <= {12'h000, capture_armed, period_armed, ff, running, cnt};
        default: begin
          o_rdata <= 32'h0000_0000;
          o_rresp <= 2'h2;
        end
      endcase
    end else if (o_rvalid && i_rready) begin
      o_rvalid  <= 1'b0;
      o_arready <= 1'b1;
    end
  end

  // The shared bit is a one-shot request in timer and event modes, so it is not kept.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      ctrl <= `MMT_CTL_RESET;
      aux  <= `MMT_AUX_RESET;
    end else begin
      if (ctl_wr) begin
        ctrl <= wdata[7:0];
        if ((wdata[2:0] == `MMT_MODE_TIMER) || (wdata[2:0] == `MMT_MODE_EVENT)) begin
          ctrl[`MMT_CTL_SHARED] <= 1'b0;
        end
      end
      if (wr_lane && awaddr == `MMT_OFS_AUX) begin
        aux <= wdata[7:0];
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (per_lo_wr) begin
      period[7:0] <= wdata[7:0];
    end
    if (per_hi_wr) begin
      period[15:8] <= wdata[7:0];
    end
  end

  always_ff @(posedge i_clk) begin
    if (soft_cap) begin
      capture <= cnt;
    end else if (cap_evt) begin
      capture <= cnt;
    end else begin
      if (cap_lo_wr) begin
        capture[7:0] <= wdata[7:0];
      end
      if (cap_hi_wr) begin
        capture[15:8] <= wdata[7:0];
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      period_armed  <= 1'b1;
      capture_armed <= 1'b1;
      hold_a        <= 3'h0;
      hold_b        <= 3'h0;
    end else begin
      if (per_lo_wr) begin
        period_armed <= 1'b0;
      end else if (per_hi_wr) begin
        period_armed <= 1'b1;
      end
      if (cap_lo_wr) begin
        capture_armed <= 1'b0;
      end else if (cap_hi_wr) begin
        capture_armed <= 1'b1;
      end
      if (per_hi_wr) begin
        hold_a <= HOLD_CYC;
      end else if (hold_a != 3'h0) begin
        hold_a <= hold_a - 3'h1;
      end
      if (cap_hi_wr) begin
        hold_b <= HOLD_CYC;
      end else if (hold_b != 3'h0) begin
        hold_b <= hold_b - 3'h1;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      pin_sync  <= 2'h0;
      slow_sync <= 2'h0;
      pin_lvl   <= 1'b0;
      pin_prev  <= 1'b0;
      filt_cnt  <= '0;
    end else begin
      pin_sync  <= {pin_sync[0], i_timer1_input_pin};
      slow_sync <= {slow_sync[0], i_slow_mode};
      pin_prev  <= pin_lvl;
      if (pin_sync[1] == pin_lvl) begin
        filt_cnt <= '0;
      end else if (filt_cnt + FILT_W'(1) >= (slow_sync[1] ? MACHINE_CYC : DETECT_CYC)) begin
        pin_lvl  <= pin_sync[1];
        filt_cnt <= '0;
      end else begin
        filt_cnt <= filt_cnt + FILT_W'(1);
      end
    end
  end

  // Divisors must be powers of two; the tick is one clock wide.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      pre  <= 16'h0000;
      tick <= 1'b0;
    end else begin
      pre <= pre + 16'h0001;
      case (aux[`MMT_AUX_CLK_MSB:`MMT_AUX_CLK_LSB])
        `MMT_CLK_SLOW: tick <= (pre & 16'(DIV_SLOW - 1)) == 16'(DIV_SLOW - 1);
        `MMT_CLK_MID:  tick <= ~slow_sync[1] & ((pre & 16'(DIV_MID - 1)) == 16'(DIV_MID - 1));
        `MMT_CLK_FAST: tick <= ~slow_sync[1] & ((pre & 16'(DIV_FAST - 1)) == 16'(DIV_FAST - 1));
        default:       tick <= 1'b0;
      endcase
    end
  end

  assign match_a = period_armed & (hold_a == 3'h0) & (inc == period);
  assign match_b = capture_armed & (hold_b == 3'h0) & (inc == capture);

  always_comb begin
    next_cnt     = cnt;
    next_running = running;
    next_phase   = phase;
    tog          = 1'b0;
    irq_evt      = 1'b0;
    cap_evt      = 1'b0;
    if (start == `MMT_START_STOP) begin
      next_cnt     = 16'h0000;
      next_running = 1'b0;
      next_phase   = MMT_PW_FIRST;
    end else begin
      case (mode)
        `MMT_MODE_TIMER: begin
          if (tick) begin
            next_cnt = match_a ? 16'h0000 : inc;
            irq_evt  = match_a;
          end
        end
        `MMT_MODE_EXT_TRIG: begin
          if (!running) begin
            next_running = trig_edge;
          end else if (ctrl[`MMT_CTL_SHARED] && opp_edge) begin
            next_cnt     = 16'h0000;
            next_running = 1'b0;
          end else if (tick) begin
            next_cnt     = match_a ? 16'h0000 : inc;
            irq_evt      = match_a;
            next_running = ~match_a;
          end
        end
        `MMT_MODE_EVENT: begin
          if (trig_edge) begin
            next_cnt = match_a ? 16'h0000 : inc;
            irq_evt  = match_a;
          end
        end
        `MMT_MODE_WINDOW: begin
          if (tick && (pin_lvl ^ aux[`MMT_AUX_TRIG_EDGE])) begin
            next_cnt = match_a ? 16'h0000 : inc;
            irq_evt  = match_a;
          end
        end
        `MMT_MODE_PWIDTH: begin
          if (!running) begin
            next_running = w_trig;
            next_phase   = MMT_PW_FIRST;
          end else if (phase == MMT_PW_FIRST && w_opp) begin
            cap_evt = 1'b1;
            irq_evt = 1'b1;
            if (ctrl[`MMT_CTL_SHARED]) begin
              next_phase = MMT_PW_SECOND;
            end else begin
              next_cnt     = 16'h0000;
              next_running = 1'b0;
            end
          end else if (phase == MMT_PW_SECOND && w_trig) begin
            cap_evt    = 1'b1;
            next_cnt   = 16'h0000;
            next_phase = MMT_PW_FIRST;
          end else if (tick) begin
            next_cnt = inc;
          end
        end
        `MMT_MODE_PPG: begin
          if (!running) begin
            next_running = (start == `MMT_START_CMD) | trig_edge;
          end else if (tick) begin
            if (match_a) begin
              next_cnt = 16'h0000;
              tog      = 1'b1;
              irq_evt  = 1'b1;
            end else begin
              next_cnt = inc;
              tog      = match_b;
              irq_evt  = match_b & ~ctrl[`MMT_CTL_PPG_MASK];
            end
          end
        end
        default: begin
          next_cnt = cnt;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      cnt                <= 16'h0000;
      running            <= 1'b0;
      phase              <= MMT_PW_FIRST;
      o_timer1_interrupt <= 1'b0;
    end else begin
      cnt                <= next_cnt;
      running            <= next_running;
      phase              <= next_phase;
      o_timer1_interrupt <= irq_evt;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      ff <= 1'b0;
    end else if (ctl_wr) begin
      ff <= wdata[`MMT_CTL_FF_INIT];
    end else if (tog) begin
      ff <= ~ff;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_pulse_output_pin <= 1'b0;
    end else begin
      o_pulse_output_pin <= ff;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  sequence s_pw_capture;
    cap_evt && !soft_cap ##1 capture == $past(cnt);
  endsequence

  a_timer_match_clear: assert property (
    (mode == `MMT_MODE_TIMER && start != `MMT_START_STOP && tick && match_a) |=> cnt == 16'h0000 && o_timer1_interrupt
    && $past(irq_evt)) else $error("timer match did not clear and interrupt");
  a_soft_capture_copy: assert property (
    soft_cap |=> capture == $past(cnt)) else $error("soft capture lost the counter value");
  a_low_byte_disarm: assert property (
    per_lo_wr |=> !period_armed ##0 !match_a) else $error("compare active after low byte write");
  a_high_byte_blank: assert property (
    per_hi_wr |=> (hold_a != 3'h0 && !match_a)[*3]) else $error("match seen inside blanking window");
  a_capture_write_gate: assert property (
    (wr_lane && awaddr == `MMT_OFS_CAPTURE_LO && mode != `MMT_MODE_PPG && !soft_cap && !cap_evt)
    |=> capture == $past(capture)) else $error("capture written outside generator mode");
  a_ext_match_halt: assert property (
    (mode == `MMT_MODE_EXT_TRIG && irq_evt) |=> !running && cnt == 16'h0000) else $error("trigger timer not halted");
  a_filter_settle: assert property (
    ($changed(pin_lvl) && !slow_sync[1] && !$past(slow_sync[1])) |-> $past(filt_cnt) == FILT_LAST)
    else $error("filter accepted a short pulse");
  a_pw_capture_seq: assert property (
    (mode == `MMT_MODE_PWIDTH && cap_evt && !soft_cap) |-> s_pw_capture) else $error("width capture missing");
  a_ppg_toggle_ff: assert property (
    (tog && !ctl_wr) |=> ff != $past(ff) ##1 o_pulse_output_pin == $past(ff)) else $error("flip-flop did not toggle");
  a_reset_clears_ff: assert property (@(posedge i_clk) disable iff (1'b0)
    i_reset |=> !ff) else $error("flip-flop not cleared by reset");
endmodule : mmt_timer
`default_nettype wire

// file: hdl/mmt_map.svh
`ifndef MMT_MAP_SVH
`define MMT_MAP_SVH

// Register byte addresses on the AXI4-Lite bus.
`define MMT_OFS_CONTROL     8'h00
`define MMT_OFS_PERIOD_LO   8'h04
`define MMT_OFS_PERIOD_HI   8'h08
`define MMT_OFS_CAPTURE_LO  8'h0c
`define MMT_OFS_CAPTURE_HI  8'h10
`define MMT_OFS_AUX         8'h14
`define MMT_OFS_STATUS      8'h18

// Control register fields.
`define MMT_CTL_MODE_LSB    0
`define MMT_CTL_MODE_MSB    2
`define MMT_CTL_PPG_MASK    3
`define MMT_CTL_START_LSB   4
`define MMT_CTL_START_MSB   5
`define MMT_CTL_SHARED      6
`define MMT_CTL_FF_INIT     7
`define MMT_CTL_RESET       8'h00

// Auxiliary register fields.
`define MMT_AUX_TRIG_EDGE   0
`define MMT_AUX_WIDTH_EDGE  1
`define MMT_AUX_CLK_LSB     2
`define MMT_AUX_CLK_MSB     3
`define MMT_AUX_RESET       8'h00

// Mode codes.
`define MMT_MODE_TIMER      3'h0
`define MMT_MODE_EXT_TRIG   3'h1
`define MMT_MODE_EVENT      3'h2
`define MMT_MODE_WINDOW     3'h3
`define MMT_MODE_PWIDTH     3'h4
`define MMT_MODE_PPG        3'h5

// Start field codes.
`define MMT_START_STOP      2'h0
`define MMT_START_CMD       2'h1
`define MMT_START_EXT       2'h2

// Clock select codes; code 3 is reserved and never ticks.
`define MMT_CLK_SLOW        2'h0
`define MMT_CLK_MID         2'h1
`define MMT_CLK_FAST        2'h2

// Timing, with fc taken as the filter reference clock.
`define MMT_CLK_HZ          40000000
`define MMT_FC_HZ           40000000
`define MMT_REJECT_FC       7
`define MMT_DETECT_FC       24
`define MMT_DETECT_CYC      ((`MMT_DETECT_FC * `MMT_CLK_HZ + `MMT_FC_HZ - 1) / `MMT_FC_HZ)
`define MMT_MACHINE_CYC     4

`endif

// file: hdl/mmt_pkg.sv
`default_nettype none
package mmt_pkg;
  typedef logic [2:0] mmt_mode_t;
  typedef logic [1:0] mmt_start_t;
  typedef logic [1:0] mmt_clk_sel_t;
  typedef enum logic [0:0] {MMT_PW_FIRST, MMT_PW_SECOND} mmt_pw_phase_t;
endpackage : mmt_pkg
`default_nettype wire

// file: verif/mmt_pin_src.sv
`default_nettype none
module mmt_pin_src (
  // Clock.
  input  wire logic i_clk,
  // Driven pin level.
  output logic      o_pin
);
  timeunit 1ns;
  timeprecision 100ps;

  initial o_pin = 1'b0;

  // timed pulse source.
  // The source drives its line at all times, so an idle pin is a solid low and never floats.
  task automatic pulse(input int hi, input int lo);
    @(posedge i_clk);
    o_pin <= 1'b1;
    repeat (hi) @(posedge i_clk);
    o_pin <= 1'b0;
    repeat (lo) @(posedge i_clk);
  endtask : pulse
endmodule : mmt_pin_src
`default_nettype wire

// file: verif/tb.sv
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk, rst, pin, pulse_output_pin, irq, slow;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  int          fails, num_checks, irq_cnt;

  mmt_timer #(.DIV_SLOW(16), .DIV_MID(4), .DIV_FAST(2)) dut_u (
    .i_clk(clk), .i_reset(rst), .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready),
    .i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp),
    .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
    .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready), .i_timer1_input_pin(pin),
    .i_slow_mode(slow), .o_pulse_output_pin(pulse_output_pin), .o_timer1_interrupt(irq));
  mmt_pin_src src_u (.i_clk(clk), .o_pin(pin));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // A non-blocking count keeps reads taken at the same edge free of races.
  always @(posedge clk) begin
    if (irq === 1'b1)
      irq_cnt <= irq_cnt + 1;
  end

  task automatic final_report;
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : final_report

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %0t value %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic check_n(input int got, input int exp);
    num_checks++;
    if (got != exp) begin
      fails++;
      $display("MISMATCH %0t count %0d expected %0d", $time, got, exp);
    end
  endtask : check_n

  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    int n;
    @(posedge clk);
    awaddr  <= a;
    wdata   <= {24'h000000, d};
    wstrb   <= 4'h1;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      if (awready === 1'b1)
        awvalid <= 1'b0;
      if (wready === 1'b1)
        wvalid <= 1'b0;
      if (bvalid === 1'b1)
        break;
    end
    bready <= 1'b0;
    check(bresp, er);
    if (n == 40) begin
      fails++;
      final_report();
    end
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      if (arready === 1'b1)
        arvalid <= 1'b0;
      if (rvalid === 1'b1)
        break;
    end
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    if (n == 40) begin
      fails++;
      final_report();
    end
  endtask : rd

  // Low byte first, so the high byte write re-arms the compare.
  task automatic wr16(input logic [7:0] a, input logic [15:0] v);
    wr(a, v[7:0], 2'h0);
    wr(a + 8'h04, v[15:8], 2'h0);
  endtask : wr16

  task automatic gap(output int t);
    for (t = 1; t < 200; t++) begin
      @(posedge clk);
      if (irq === 1'b1)
        break;
    end
    if (t == 200) begin
      fails++;
      final_report();
    end
  endtask : gap

  task automatic run(input logic lv, output int t);
    for (t = 0; t < 100; t++) begin
      if (pulse_output_pin !== lv)
        break;
      @(posedge clk);
    end
    if (t == 100) begin
      fails++;
      final_report();
    end
  endtask : run

  task automatic sc_map;
    logic [31:0] d;
    logic [1:0]  r;
    rd(8'h00, d, r);
    check(d, 32'h00000000);
    rd(8'h18, d, r);
    check(d[17], 1'b0);
    rd(8'h1c, d, r);
    check(r, 2'h2);
    wr(8'h1c, 8'h00, 2'h2);
  endtask : sc_map

  task automatic sc_ppg;
    logic [31:0] d;
    logic [1:0]  r;
    int          t, n;
    wr(8'h14, 8'h08, 2'h0);
    wr(8'h00, 8'h05, 2'h0);
    wr16(8'h04, 16'h0006);
    wr16(8'h0c, 16'h0002);
    rd(8'h0c, d, r);
    check(d[15:0], 16'h0002);
    wr(8'h00, 8'h15, 2'h0);
    run(1'b0, t);
    run(1'b1, t);
    check_n(t, 8);
    run(1'b0, t);
    check_n(t, 4);
    n = irq_cnt;
    repeat (60) @(posedge clk);
    check_n(irq_cnt - n, 10);
    wr(8'h00, 8'h05, 2'h0);
    wr(8'h00, 8'h85, 2'h0);
    @(posedge clk);
    check(pulse_output_pin, 1'b1);
    wr(8'h00, 8'h0d, 2'h0);
    wr(8'h00, 8'h1d, 2'h0);
    gap(t);
    n = irq_cnt;
    repeat (60) @(posedge clk);
    check_n(irq_cnt - n, 5);
  endtask : sc_ppg

  task automatic sc_timer;
    logic [31:0] d;
    logic [1:0]  r;
    int          t, n;
    wr(8'h00, 8'h00, 2'h0);
    wr16(8'h0c, 16'h0077);
    rd(8'h0c, d, r);
    check(d[15:0], 16'h0002);
    wr16(8'h04, 16'h0003);
    wr(8'h00, 8'h10, 2'h0);
    gap(t);
    gap(t);
    check_n(t, 6);
    wr(8'h04, 8'h03, 2'h0);
    n = irq_cnt;
    repeat (60) @(posedge clk);
    check_n(irq_cnt - n, 0);
    wr(8'h08, 8'h00, 2'h0);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd(8'h0c, d, r);
    check(d[15:0], 16'h0002);
    wr(8'h00, 8'h10, 2'h0);
    gap(t);
    gap(t);
    check_n(t, 48);
    repeat (20) @(posedge clk);
    wr(8'h00, 8'h50, 2'h0);
    rd(8'h0c, d, r);
    check(d[15:0], 16'h0001);
  endtask : sc_timer

  task automatic sc_event;
    int n;
    wr(8'h00, 8'h02, 2'h0);
    wr(8'h14, 8'h08, 2'h0);
    wr(8'h00, 8'h12, 2'h0);
    n = irq_cnt;
    src_u.pulse(7, 40);
    src_u.pulse(30, 40);
    src_u.pulse(30, 40);
    check_n(irq_cnt - n, 0);
    src_u.pulse(30, 40);
    check_n(irq_cnt - n, 1);
    slow <= 1'b1;
    src_u.pulse(6, 20);
    src_u.pulse(6, 20);
    src_u.pulse(6, 20);
    check_n(irq_cnt - n, 2);
    slow <= 1'b0;
    wr(8'h00, 8'h02, 2'h0);
    wr(8'h00, 8'h13, 2'h0);
    n = irq_cnt;
    repeat (60) @(posedge clk);
    check_n(irq_cnt - n, 0);
    src_u.pulse(32, 40);
    check_n(irq_cnt - n, 5);
  endtask : sc_event

  task automatic sc_trig;
    int n;
    wr(8'h00, 8'h01, 2'h0);
    wr(8'h14, 8'h04, 2'h0);
    wr16(8'h04, 16'h001e);
    wr(8'h00, 8'h21, 2'h0);
    n = irq_cnt;
    repeat (150) @(posedge clk);
    check_n(irq_cnt - n, 0);
    src_u.pulse(100, 100);
    check_n(irq_cnt - n, 1);
    wr(8'h00, 8'h01, 2'h0);
    wr(8'h00, 8'h61, 2'h0);
    n = irq_cnt;
    src_u.pulse(30, 120);
    check_n(irq_cnt - n, 0);
  endtask : sc_trig

  task automatic sc_width;
    logic [31:0] d;
    logic [1:0]  r;
    int          n;
    wr(8'h00, 8'h04, 2'h0);
    wr(8'h00, 8'h24, 2'h0);
    n = irq_cnt;
    src_u.pulse(40, 60);
    check_n(irq_cnt - n, 1);
    rd(8'h0c, d, r);
    check_n(int'(d[15:0] >= 16'd8 && d[15:0] <= 16'd12), 1);
    wr(8'h00, 8'h04, 2'h0);
    wr(8'h00, 8'h64, 2'h0);
    n = irq_cnt;
    src_u.pulse(40, 60);
    src_u.pulse(40, 0);
    check_n(irq_cnt - n, 1);
    rd(8'h0c, d, r);
    check_n(int'(d[15:0] >= 16'd23 && d[15:0] <= 16'd27), 1);
  endtask : sc_width

  initial begin
    rst        = 1'b1;
    slow       = 1'b0;
    awvalid    = 1'b0;
    wvalid     = 1'b0;
    bready     = 1'b0;
    arvalid    = 1'b0;
    rready     = 1'b0;
    awaddr     = 8'h00;
    araddr     = 8'h00;
    wdata      = 32'h00000000;
    wstrb      = 4'h0;
    fails      = 0;
    num_checks = 0;
    irq_cnt    = 0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    sc_map();
    sc_ppg();
    sc_timer();
    sc_event();
    sc_trig();
    sc_width();
    final_report();
  end
endmodule : tb
`default_nettype wire
